// File: rtl/gsbc_core.sv
// Gate-supply undervoltage protection and boost regulation control logic.
`default_nettype none
module gsbc_core #(
	parameter int FILTER_CYCLES = gsbc_pkg::UV_FILTER_CYCLES
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SRST,
	// Register port.
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [8:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	// Analog comparators and pins.
	input wire logic GATE_SUPPLY_UNDERVOLTAGE,
	input wire logic LOGIC_SUPPLY_UNDERVOLTAGE,
	input wire logic BATTERY_OK,
	input wire logic CLOCK_OK,
	input wire logic DRIVER_ENABLE_PIN,
	input wire logic BOOST_VOLTAGE_HIGH,
	input wire logic CURRENT_ABOVE_LOW,
	input wire logic CURRENT_ABOVE_HIGH,
	input wire logic CURRENT_NEGATIVE_OVER,
	input wire logic CHANNEL_SWITCH_REQUEST,
	// Outputs.
	output logic GATE_DRIVERS_ENABLE,
	output logic BOOST_SWITCH_DRIVER,
	output logic INTERRUPT_REQUEST_N,
	output logic [7:0] BOOST_THRESHOLD_CODE,
	output logic [4:0] CURRENT_LOW_THRESHOLD,
	output logic [4:0] CURRENT_HIGH_THRESHOLD,
	output logic [4:0] CURRENT_NEGATIVE_THRESHOLD
);
	// Two-stage synchronisers for all asynchronous comparator and pin inputs except CHANNEL_SWITCH_REQUEST, which is used unsynchronised.
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] async_in, sync1_reg, sync2_reg;
	assign async_in = {GATE_SUPPLY_UNDERVOLTAGE, LOGIC_SUPPLY_UNDERVOLTAGE, BATTERY_OK, CLOCK_OK,
		DRIVER_ENABLE_PIN, BOOST_VOLTAGE_HIGH, CURRENT_ABOVE_LOW, CURRENT_ABOVE_HIGH,
		CURRENT_NEGATIVE_OVER};
	always_ff @(posedge CLK) begin
		if (SRST) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end
	wire uv_gate = sync2_reg[8];
	wire uv_logic = sync2_reg[7];
	wire batt_ok = sync2_reg[6];
	wire clk_ok = sync2_reg[5];
	wire drv_en_pin = sync2_reg[4];
	wire vboost_high_raw = sync2_reg[3];
	wire i_above_low = sync2_reg[2];
	wire i_above_high = sync2_reg[1];
	wire i_neg_over = sync2_reg[0];

	// Registers.
	logic [15:0] launch0_reg, launch1_reg, vthresh_reg, vfilter_reg, drvcfg_reg;
	logic [15:0] current_reg, bctrl_reg, faults_reg;
	// Address decode shared by the write strobes and the read selector.
	function automatic logic reg_hit(input logic [8:0] addr, input logic [8:0] ofs);
		return addr == ofs;
	endfunction
	wire wr_launch0 = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_LAUNCH0);
	wire wr_launch1 = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_LAUNCH1);
	wire wr_vthresh = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_VTHRESH);
	wire wr_vfilter = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_VFILTER);
	wire wr_drvcfg = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_DRVCFG);
	wire wr_current = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_CURRENT);
	wire wr_bctrl = REG_WR && reg_hit(REG_ADDR, gsbc_pkg::OFS_BCTRL);
	wire rd_faults = REG_RD && reg_hit(REG_ADDR, gsbc_pkg::OFS_FAULTS);
	// Program launch from either bank enables the regulator.
	wire launched = launch0_reg[gsbc_pkg::LAUNCH_BIT] | launch1_reg[gsbc_pkg::LAUNCH_BIT];
	wire ovr_bit = drvcfg_reg[gsbc_pkg::CFG_OVR_BIT];
	wire irq_en = drvcfg_reg[gsbc_pkg::CFG_IRQEN_BIT];
	wire run_bit = bctrl_reg[gsbc_pkg::CTL_RUN_BIT];
	wire fixed_mode = bctrl_reg[gsbc_pkg::CTL_FIXED_BIT];
	wire injecting = bctrl_reg[gsbc_pkg::CTL_INJ_BIT];
	wire fixed_sw = bctrl_reg[gsbc_pkg::CTL_FSW_BIT];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			launch0_reg <= '0;
			launch1_reg <= '0;
			vthresh_reg <= gsbc_pkg::VTHRESH_RESET;
			vfilter_reg <= gsbc_pkg::VFILTER_RESET;
			drvcfg_reg <= gsbc_pkg::DRVCFG_RESET;
			current_reg <= gsbc_pkg::CURRENT_RESET;
			bctrl_reg <= '0;
		end else begin
			if (wr_launch0) launch0_reg <= REG_WDATA;
			if (wr_launch1) launch1_reg <= REG_WDATA;
			// Soft start is the program stepping this word upward write by write.
			if (wr_vthresh) vthresh_reg <= {8'h00, REG_WDATA[7:0]};
			if (wr_vfilter) vfilter_reg <= REG_WDATA;
			if (wr_drvcfg) drvcfg_reg <= REG_WDATA;
			if (wr_current) current_reg <= {1'b0, REG_WDATA[14:0]};
			if (wr_bctrl) bctrl_reg <= REG_WDATA;
		end
	end

	// Recovery anti-glitch filter: counter restarts while undervoltage is present.
	logic [15:0] uv_cnt_reg;
	logic uv_block_reg;
	always_ff @(posedge CLK) begin
		if (SRST) begin
			uv_cnt_reg <= '0;
			uv_block_reg <= 1'b1;
		end else if (uv_gate) begin
			uv_cnt_reg <= '0;
			uv_block_reg <= 1'b1;
		end else if (uv_block_reg) begin
			if (uv_cnt_reg >= 16'(FILTER_CYCLES - 1)) begin
				uv_block_reg <= 1'b0;
			end else begin
				uv_cnt_reg <= uv_cnt_reg + 16'h0001;
			end
		end
	end
	wire drivers_ok = !uv_block_reg && !uv_gate && !uv_logic;

	// Boost comparator filter: count in low byte, type bit selects
	// symmetric (both edges) or rising-only filtering.
	logic [7:0] vf_cnt_reg;
	logic vboost_high_reg;
	wire filt_type = vfilter_reg[gsbc_pkg::FIL_TYPE_BIT];
	wire vf_differs = vboost_high_raw != vboost_high_reg;
	wire vf_bypass = filt_type && !vboost_high_raw;
	wire vf_expired = vf_cnt_reg >= vfilter_reg[7:0];
	always_ff @(posedge CLK) begin
		if (SRST) begin
			vf_cnt_reg <= '0;
			vboost_high_reg <= 1'b0;
		end else if (!vf_differs || vf_bypass) begin
			vf_cnt_reg <= '0;
			vboost_high_reg <= vboost_high_raw;
		end else if (vf_expired) begin
			vf_cnt_reg <= '0;
			vboost_high_reg <= vboost_high_raw;
		end else begin
			vf_cnt_reg <= vf_cnt_reg + 8'h01;
		end
	end
	// Settling timer restarts on every threshold write.
	logic [7:0] settle_cnt_reg;
	wire settled = settle_cnt_reg >= vfilter_reg[7:0];
	always_ff @(posedge CLK) begin
		if (SRST || wr_vthresh) settle_cnt_reg <= '0;
		else if (!settled) settle_cnt_reg <= settle_cnt_reg + 8'h01;
	end

	// Voltage loop state machine.
	gsbc_pkg::gsbc_state_t state_reg, state_next;
	wire boost_allowed = batt_ok && launched && run_bit;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			gsbc_pkg::GSBC_IDLE: if (boost_allowed && wr_vthresh) state_next = gsbc_pkg::GSBC_SETTLE;
			gsbc_pkg::GSBC_SETTLE: if (settled) begin
				state_next = vboost_high_reg ? gsbc_pkg::GSBC_IDLE : gsbc_pkg::GSBC_SWITCH;
			end
			gsbc_pkg::GSBC_SWITCH: if (vboost_high_reg) state_next = gsbc_pkg::GSBC_PAUSE;
			gsbc_pkg::GSBC_PAUSE: if (settled && !vboost_high_reg) state_next = gsbc_pkg::GSBC_IDLE;
		endcase
		if (!boost_allowed) state_next = gsbc_pkg::GSBC_IDLE;
	end
	always_ff @(posedge CLK) begin
		if (SRST) state_reg <= gsbc_pkg::GSBC_IDLE;
		else state_reg <= state_next;
	end

	// Hardware current loop, active in variable mode during switching.
	logic cur_on_reg;
	wire cur_loop_en = state_reg == gsbc_pkg::GSBC_SWITCH && !fixed_mode;
	always_ff @(posedge CLK) begin
		if (SRST || !cur_loop_en) cur_on_reg <= 1'b0;
		else if (i_above_high) cur_on_reg <= 1'b0;
		else if (!i_above_low) cur_on_reg <= 1'b1;
	end
	// Variable mode suspends during injection; fixed mode follows the program bit.
	wire var_req = cur_on_reg && !injecting;
	wire fix_req = state_reg == gsbc_pkg::GSBC_SWITCH && fixed_mode && fixed_sw;
	wire channel_req = CHANNEL_SWITCH_REQUEST && (var_req || fix_req);
	wire pin_ok = drv_en_pin || ovr_bit;
	wire sw_cmd = pin_ok && drivers_ok && clk_ok && channel_req && batt_ok;

	// Fault flags: set wins over clear-on-read.
	wire neg_oc_evt = i_neg_over && !fixed_mode;
	logic [15:0] faults_next;
	always_comb begin
		faults_next = rd_faults ? 16'h0000 : faults_reg;
		if (uv_gate) faults_next[gsbc_pkg::FLT_UV_BIT] = 1'b1;
		if (uv_logic) faults_next[gsbc_pkg::FLT_LOGIC_UV_BIT] = 1'b1;
		if (neg_oc_evt) faults_next[gsbc_pkg::FLT_NEG_OC_BIT] = 1'b1;
	end
	wire [15:0] rd_mux =
		reg_hit(REG_ADDR, gsbc_pkg::OFS_LAUNCH0) ? launch0_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_LAUNCH1) ? launch1_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_VTHRESH) ? vthresh_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_VFILTER) ? vfilter_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_DRVCFG) ? drvcfg_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_FAULTS) ? faults_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_CURRENT) ? current_reg :
		reg_hit(REG_ADDR, gsbc_pkg::OFS_BCTRL) ? {14'h0000, state_reg} : 16'h0000;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			faults_reg <= '0;
			REG_RDATA <= '0;
			GATE_DRIVERS_ENABLE <= 1'b0;
			BOOST_SWITCH_DRIVER <= 1'b0;
			INTERRUPT_REQUEST_N <= 1'b1;
			BOOST_THRESHOLD_CODE <= '0;
			CURRENT_LOW_THRESHOLD <= '0;
			CURRENT_HIGH_THRESHOLD <= '0;
			CURRENT_NEGATIVE_THRESHOLD <= '0;
		end else begin
			faults_reg <= faults_next;
			REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
			GATE_DRIVERS_ENABLE <= drivers_ok;
			BOOST_SWITCH_DRIVER <= sw_cmd;
			INTERRUPT_REQUEST_N <= !(irq_en && faults_next[gsbc_pkg::FLT_UV_BIT]);
			BOOST_THRESHOLD_CODE <= vthresh_reg[7:0];
			CURRENT_LOW_THRESHOLD <= current_reg[4:0];
			CURRENT_HIGH_THRESHOLD <= current_reg[9:5];
			CURRENT_NEGATIVE_THRESHOLD <= current_reg[14:10];
		end
	end
endmodule
`default_nettype wire

// File: rtl/gsbc_pkg.sv
// Package of register offsets, field positions, reset values and timing counts for the boost block.
// Notes on behaviour
// - Gate-supply undervoltage forces all gate drivers off.
// - Re-enable only after recovery and filter delay.
// - Undervoltage sets status flag, optional interrupt.
// - Boost needs battery ok and no reset.
// - Override bit 0 lets enable pin inhibit.
// - Voltage threshold is an 8-bit register word.
// - Voltage comparator filtered, programmable time and type.
// - Two 5-bit current thresholds bound switch current.
// - Negative current overcurrent flagged, variable mode only.
// - Switch while output low, stop when high.
// - Variable mode: on below low, off above high.
// - Hardware times current edges once enabled.
// - Variable mode suspends during injection phases.
// - Variable mode threshold and filter sequence.
// - Fixed mode: program times on and off.
// - Fixed mode loads upper threshold, settles, switches.
// - Fixed mode keeps switching during injection.
// - Regulation starts at launch, gated by pin.
// - Soft start by stepping threshold word upward.
// - Switch command needs enable, supplies, clock, request.
`default_nettype none
package gsbc_pkg;
	localparam logic [8:0] OFS_LAUNCH0 = 9'h100;
	localparam logic [8:0] OFS_LAUNCH1 = 9'h120;
	localparam logic [8:0] OFS_VTHRESH = 9'h19B;
	localparam logic [8:0] OFS_VFILTER = 9'h19D;
	localparam logic [8:0] OFS_DRVCFG = 9'h1C5;
	localparam logic [8:0] OFS_FAULTS = 9'h1D2;
	localparam logic [8:0] OFS_CURRENT = 9'h1A0;
	localparam logic [8:0] OFS_BCTRL = 9'h1A1;
	localparam int LAUNCH_BIT = 0;
	localparam int CFG_OVR_BIT = 0;
	localparam int CFG_IRQEN_BIT = 1;
	localparam int FLT_UV_BIT = 0;
	localparam int FLT_LOGIC_UV_BIT = 1;
	localparam int FLT_NEG_OC_BIT = 2;
	localparam int CTL_RUN_BIT = 0;
	localparam int CTL_FIXED_BIT = 1;
	localparam int CTL_INJ_BIT = 2;
	localparam int CTL_FSW_BIT = 3;
	localparam int FIL_TYPE_BIT = 8;
	localparam logic [15:0] DRVCFG_RESET = 16'h0001;
	localparam logic [15:0] VTHRESH_RESET = 16'h0000;
	localparam logic [15:0] VFILTER_RESET = 16'h0004;
	localparam logic [15:0] CURRENT_RESET = 16'h0000;
	localparam int CLK_MHZ = 125;
	localparam int UV_FILTER_NS = 1300;
	localparam int UV_FILTER_MIN_NS = 800;
	localparam int UV_FILTER_CYCLES = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [1:0] {
		GSBC_IDLE = 2'b00,
		GSBC_SETTLE = 2'b01,
		GSBC_SWITCH = 2'b10,
		GSBC_PAUSE = 2'b11
	} gsbc_state_t;
endpackage
`default_nettype wire

// File: sim/gsbc_boost_model.sv
// Behavioural boost stage with its output voltage and switch current comparators.
`default_nettype none
module gsbc_boost_model (
	// Clock and switch command.
	input wire logic clk,
	input wire logic sw_on,
	// Thresholds and comparator outputs.
	input wire logic [7:0] v_code,
	input wire logic [4:0] lo_code,
	input wire logic [4:0] hi_code,
	output logic v_high,
	output logic i_low,
	output logic i_high
);
	timeunit 1ns;
	timeprecision 1ps;
	int v = 0;
	int i = 0;
	int t = 0;
	// Current ramps while the switch conducts; the output leaks slowly once the current has died.
	always @(posedge clk) begin
		t <= t + 1;
		if (sw_on) begin
			v <= (v < 255) ? v + 1 : v;
			i <= (i < 40) ? i + 2 : i;
		end else begin
			v <= (v > 0 && i == 0 && t % 8 == 0) ? v - 1 : v;
			i <= (i > 0) ? i - 1 : 0;
		end
	end
	assign v_high = v > v_code;
	assign i_low = i > lo_code;
	assign i_high = i > hi_code;
endmodule
`default_nettype wire

// File: sim/gsbc_core_asserts.sv
// Port checker for the gate-supply and boost control block.
`default_nettype none
module gsbc_core_asserts #(
	parameter int FILTER_CYCLES = 4
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SRST,
	// Conditions.
	input wire logic GATE_SUPPLY_UNDERVOLTAGE,
	input wire logic LOGIC_SUPPLY_UNDERVOLTAGE,
	input wire logic BATTERY_OK,
	input wire logic CLOCK_OK,
	input wire logic CHANNEL_SWITCH_REQUEST,
	// Outputs.
	input wire logic GATE_DRIVERS_ENABLE,
	input wire logic BOOST_SWITCH_DRIVER,
	input wire logic INTERRUPT_REQUEST_N
);
	logic [15:0] low_cnt;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SRST);
	// Counts edges since the raw undervoltage input was last high.
	always_ff @(posedge CLK) begin
		if (SRST || GATE_SUPPLY_UNDERVOLTAGE) begin
			low_cnt <= 16'h0000;
		end else if (low_cnt != 16'hFFFF) begin
			low_cnt <= low_cnt + 16'h0001;
		end
	end
	chk_uv_gates_off: assert property (
		GATE_SUPPLY_UNDERVOLTAGE [*3] |=> !GATE_DRIVERS_ENABLE) else $error("gates on in uv");
	chk_uv_switch_off: assert property (
		GATE_SUPPLY_UNDERVOLTAGE [*3] |=> !BOOST_SWITCH_DRIVER) else $error("switch on in uv");
	chk_recover_filter: assert property (
		$rose(GATE_DRIVERS_ENABLE) |-> low_cnt >= FILTER_CYCLES) else $error("early re-enable");
	chk_battery_low_off: assert property (
		!BATTERY_OK [*3] |=> !BOOST_SWITCH_DRIVER) else $error("switch on, battery low");
	chk_clock_bad_off: assert property (
		!CLOCK_OK [*3] |=> !BOOST_SWITCH_DRIVER) else $error("switch on, clock bad");
	chk_logic_uv_off: assert property (
		LOGIC_SUPPLY_UNDERVOLTAGE [*3] |=> !BOOST_SWITCH_DRIVER) else $error("switch on in luv");
	chk_no_request_off: assert property (
		!CHANNEL_SWITCH_REQUEST [*3] |=> !BOOST_SWITCH_DRIVER) else $error("switch unrequested");
	chk_reset_quiet: assert property (disable iff (1'b0)
		SRST |=> !BOOST_SWITCH_DRIVER && !GATE_DRIVERS_ENABLE && INTERRUPT_REQUEST_N)
		else $error("outputs active in reset");
endmodule
bind gsbc_core gsbc_core_asserts #(.FILTER_CYCLES(FILTER_CYCLES)) chk (.CLK, .SRST,
	.GATE_SUPPLY_UNDERVOLTAGE, .LOGIC_SUPPLY_UNDERVOLTAGE, .BATTERY_OK, .CLOCK_OK,
	.CHANNEL_SWITCH_REQUEST, .GATE_DRIVERS_ENABLE, .BOOST_SWITCH_DRIVER, .INTERRUPT_REQUEST_N);
`default_nettype wire

// File: sim/tb_gsbc_core.sv
// Self-checking bench for the gate-supply and boost control block.
`default_nettype none
module tb_gsbc_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FILT = 4;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic uv = 1'b0;
	logic pin = 1'b1;
	logic nov = 1'b0;
	logic [3:0] bad = 4'h0;
	logic [8:0] addr = 9'h000;
	logic [15:0] wdat = 16'h0000;
	logic [31:0] seed = 32'h24971537;
	int n_mismatch = 0;
	int compares = 0;
	int cnt;
	wire logic [15:0] rdat;
	wire logic gde, sw, irq_n, vh, al, ah;
	wire logic [7:0] vth;
	wire logic [4:0] lo, hi, ng;
	always #4 CLK = ~CLK;
	gsbc_core #(.FILTER_CYCLES(FILT)) dut (.CLK(CLK), .SRST(SRST), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wdat), .REG_RDATA(rdat), .GATE_SUPPLY_UNDERVOLTAGE(uv),
		.LOGIC_SUPPLY_UNDERVOLTAGE(bad[2]), .BATTERY_OK(!bad[0]), .CLOCK_OK(!bad[1]),
		.DRIVER_ENABLE_PIN(pin), .BOOST_VOLTAGE_HIGH(vh), .CURRENT_ABOVE_LOW(al),
		.CURRENT_ABOVE_HIGH(ah), .CURRENT_NEGATIVE_OVER(nov), .CHANNEL_SWITCH_REQUEST(!bad[3]),
		.GATE_DRIVERS_ENABLE(gde), .BOOST_SWITCH_DRIVER(sw), .INTERRUPT_REQUEST_N(irq_n),
		.BOOST_THRESHOLD_CODE(vth), .CURRENT_LOW_THRESHOLD(lo), .CURRENT_HIGH_THRESHOLD(hi),
		.CURRENT_NEGATIVE_THRESHOLD(ng));
	gsbc_boost_model far (.clk(CLK), .sw_on(sw), .v_code(vth), .lo_code(lo), .hi_code(hi),
		.v_high(vh), .i_low(al), .i_high(ah));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic wreg(input logic [8:0] a, input logic [15:0] d);
		wr = 1'b1;
		addr = a;
		wdat = d;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rreg(input logic [8:0] a, input logic [15:0] e);
		rd = 1'b1;
		addr = a;
		tick(1);
		rd = 1'b0;
		chk(rdat, e);
		tick(1);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Waits for gate enable (0), switch (1) or output high (2), counting cycles in cnt.
	task automatic waitsig(input int w, input int lim);
		cnt = 0;
		while ((w == 0 ? gde : w == 1 ? sw : vh) !== 1'b1 && cnt < lim) begin
			tick(1);
			cnt++;
		end
		if (cnt == lim) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: wait %0d ran out", $time, w);
			conclude();
		end
	endtask
	initial begin
		tick(3);
		SRST = 1'b0;
		waitsig(0, 40);
		chk(16'(cnt >= FILT), 16'h0001);
		wreg(gsbc_pkg::OFS_FAULTS, 16'hFFFF);
		wreg(9'h0F0, 16'hFFFF);
		rreg(9'h0F0, 16'h0000);
		rreg(gsbc_pkg::OFS_FAULTS, 16'h0000);
		rreg(gsbc_pkg::OFS_DRVCFG, gsbc_pkg::DRVCFG_RESET);
		rreg(gsbc_pkg::OFS_VFILTER, gsbc_pkg::VFILTER_RESET);
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			wreg(gsbc_pkg::OFS_VTHRESH, seed[15:0]);
			wreg(gsbc_pkg::OFS_CURRENT, seed[31:16]);
			chk(16'(vth), 16'(seed[7:0]));
			chk(16'({ng, hi, lo}), 16'(seed[30:16]));
		end
		$display("test registers done");
		wreg(gsbc_pkg::OFS_CURRENT, 16'h7E88);
		wreg(gsbc_pkg::OFS_BCTRL, 16'h0001);
		wreg(gsbc_pkg::OFS_LAUNCH0, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			wreg(gsbc_pkg::OFS_VTHRESH, 16'(40 * (k + 1)));
			waitsig(1, 400);
			bad[k] = 1'b1;
			tick(4);
			chk(16'(sw), 16'h0000);
			bad = 4'h0;
			tick(3);
			wreg(gsbc_pkg::OFS_VTHRESH, 16'(40 * (k + 1)));
			waitsig(2, 3000);
			tick(12);
			chk(16'(sw), 16'h0000);
			wreg(gsbc_pkg::OFS_VTHRESH, 16'(40 * (k + 2)));
			tick(12);
			rreg(gsbc_pkg::OFS_BCTRL, 16'h0000);
		end
		wreg(gsbc_pkg::OFS_DRVCFG, 16'h0002);
		pin = 1'b0;
		wreg(gsbc_pkg::OFS_VTHRESH, 16'h00E6);
		tick(20);
		chk(16'(sw), 16'h0000);
		pin = 1'b1;
		waitsig(1, 60);
		rreg(gsbc_pkg::OFS_FAULTS, 16'h0002);
		wreg(gsbc_pkg::OFS_BCTRL, 16'h0005);
		tick(40);
		chk(16'(sw), 16'h0000);
		wreg(gsbc_pkg::OFS_BCTRL, 16'h000F);
		chk(16'(sw), 16'h0001);
		waitsig(2, 300);
		tick(12);
		chk(16'(sw), 16'h0000);
		for (int m = 0; m < 2; m++) begin
			wreg(gsbc_pkg::OFS_BCTRL, m ? 16'h0001 : 16'h000F);
			nov = 1'b1;
			tick(3);
			nov = 1'b0;
			tick(3);
			rreg(gsbc_pkg::OFS_FAULTS, m ? 16'h0004 : 16'h0000);
		end
		$display("test boost done");
		uv = 1'b1;
		tick(3);
		chk(16'({gde, sw, irq_n}), 16'h0000);
		rreg(gsbc_pkg::OFS_FAULTS, 16'h0001);
		uv = 1'b0;
		tick(2);
		uv = 1'b1;
		tick(1);
		uv = 1'b0;
		waitsig(0, 100);
		chk(16'(cnt > FILT), 16'h0001);
		rreg(gsbc_pkg::OFS_FAULTS, 16'h0001);
		rreg(gsbc_pkg::OFS_FAULTS, 16'h0000);
		chk(16'(irq_n), 16'h0001);
		SRST = 1'b1;
		tick(2);
		chk(16'({gde, sw, irq_n}), 16'h0001);
		SRST = 1'b0;
		$display("test undervoltage done");
		conclude();
	end
endmodule
`default_nettype wire
